//--- pmicsq_defs.svh
`ifndef PMICSQ_DEFS_SVH
`define PMICSQ_DEFS_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define PMICSQ_IDX_LIN_REG 6'h1B
`define PMICSQ_IDX_DLY_LOW 6'h20
`define PMICSQ_IDX_DLY_HIGH 6'h21
`define PMICSQ_IDX_RAIL_SLOT 6'h22
`define PMICSQ_IDX_STATUS 6'h30
`define PMICSQ_IDX_CONTROL 6'h31
`define PMICSQ_IDX_UNLOCK 6'h32

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define PMICSQ_RST_LIN_REG 6'h1F
`define PMICSQ_RST_LIN_MV 12'h708
`define PMICSQ_RST_DLY_LOW 8'h00
`define PMICSQ_RST_DLY_HIGH 8'h00
`define PMICSQ_RST_RAIL_SLOT 8'h55
`define PMICSQ_BIT_MULT 7
`define PMICSQ_BIT_GAP9 0
`define PMICSQ_BIT_START_UP 0
`define PMICSQ_BIT_START_DOWN 1
`define PMICSQ_UNLOCK_KEY 8'hA5

// ****************************************************************
// slot and voltage code figures
// ****************************************************************
`define PMICSQ_SLOT_FIRST 4'h1
`define PMICSQ_SLOT_LAST 4'hA
`define PMICSQ_RAIL_SLOT_MIN 4'h3
`define PMICSQ_LIN_FINE_TOP 6'h19
`define PMICSQ_LIN_COARSE_BASE 6'h1A
`define PMICSQ_LIN_FINE_MV0 12'h384
`define PMICSQ_LIN_FINE_STEP 12'h019
`define PMICSQ_LIN_COARSE_MV0 12'h60E
`define PMICSQ_LIN_COARSE_STEP 12'h032

// ****************************************************************
// timing
// ****************************************************************
`define PMICSQ_CLK_PERIOD_NS 10
`define PMICSQ_MS_NS 1000000
`define PMICSQ_CYC_PER_MS (`PMICSQ_MS_NS / `PMICSQ_CLK_PERIOD_NS)
`define PMICSQ_GAP_SHORT_MS 8'h02
`define PMICSQ_GAP_LONG_MS 8'h05
`define PMICSQ_DOWN_FACTOR 8'h0A
`define PMICSQ_BLANK_MS 8'h05

`endif

//--- pmicsq_pkg.sv
package pmicsq_pkg;

  // sequencer states, gray along idle -> up -> down
  typedef enum logic [1:0] {
    PMICSQ_IDLE = 2'b00,
    PMICSQ_UP = 2'b01,
    PMICSQ_DOWN = 2'b11
  } pmicsq_state_t;

  typedef logic [3:0] pmicsq_slot_t;

endpackage : pmicsq_pkg

//--- pmicsq_ms_timer.sv
`timescale 1ns/1ps
`include "pmicsq_defs.svh"

module pmicsq_ms_timer #(
  parameter int CYC_PER_MS = `PMICSQ_CYC_PER_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic [7:0] load_ms,
  // result
  output logic busy,
  output logic done
);

  logic [31:0] pre_cnt;
  logic [7:0] ms_left;
  wire ms_tick = (pre_cnt == 32'(CYC_PER_MS - 1));

  // the prescaler needs at least two cycles per millisecond
  if (CYC_PER_MS < 2) begin : g_cyc_check
    $error("pmicsq_ms_timer: CYC_PER_MS must be at least 2");
  end

  // one-cycle enable every millisecond while counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 32'h0;
    end else if (load || !busy || ms_tick) begin
      pre_cnt <= 32'h0;
    end else begin
      pre_cnt <= pre_cnt + 32'h1;
    end
  end

  // millisecond down counter, done pulses as it reaches zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_left <= 8'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      ms_left <= load_ms;
      busy <= (load_ms != 8'h0);
      done <= (load_ms == 8'h0);
    end else begin
      done <= busy && ms_tick && (ms_left == 8'h1);
      if (busy && ms_tick) begin
        ms_left <= ms_left - 8'h1;
        busy <= (ms_left != 8'h1);
      end
    end
  end

endmodule : pmicsq_ms_timer

//--- pmicsq_top.sv
//
// Function
// - codes 1Ah..3Fh give 1.550 V to 3.400 V in 50 mV steps.
// - one programmable gap after slot n, selected by low delay bit n-1, n=1..8.
// - a gap select bit gives 2 ms when clear, 5 ms when set.
// - gap between slot 9 and slot 10 comes from high register bit 0.
// - multiplier bit set makes every power-down gap ten times longer.
// - power-up gaps ignore the multiplier bit.
// - rail slot field 3h..Ah enables rail at slot 3..10; rail 2 high nibble.
// - rail slot field 0h..2h or Bh..Fh leaves the rail untouched.
// - codes 0h..19h give 0.900 V to 1.525 V in 25 mV; reset 1Fh.
// - any write to the regulator voltage blanks its monitors for 5 ms.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pmicsq_defs.svh"

module pmicsq_top #(
  parameter int CYC_PER_MS = `PMICSQ_CYC_PER_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // regulator and rails
  output logic [5:0] linear_regulator_voltage,
  output logic [11:0] lin_reg_target_mv,
  output logic lin_reg_monitor_blank,
  output logic buck_rail_one,
  output logic buck_rail_two,
  // sequencer progress
  output logic slot_strobe,
  output pmicsq_pkg::pmicsq_slot_t slot_now,
  output logic seq_busy
);

  import pmicsq_pkg::*;

  // refuse a prescale the timers cannot serve
  if (CYC_PER_MS < 2) begin : g_cyc_check
    $error("pmicsq_top: CYC_PER_MS must be at least 2");
  end

  // ****************************************************************
  // functions
  // ****************************************************************

  // millivolt target of a regulator code
  function automatic logic [11:0] lin_code_mv(input logic [5:0] code);
    logic [11:0] off;
    off = 12'h0;
    if (code <= `PMICSQ_LIN_FINE_TOP) begin
      off = {6'h0, code};
      lin_code_mv = `PMICSQ_LIN_FINE_MV0 + 12'(off * `PMICSQ_LIN_FINE_STEP);
    end else begin
      off = {6'h0, code - `PMICSQ_LIN_COARSE_BASE};
      lin_code_mv = `PMICSQ_LIN_COARSE_MV0 + 12'(off * `PMICSQ_LIN_COARSE_STEP);
    end
  endfunction : lin_code_mv

  // gap after slot n in milliseconds, scaled on the way down
  function automatic logic [7:0] gap_ms(input logic [8:0] sel, input logic [3:0] n,
                                        input logic down, input logic mult);
    logic [7:0] base;
    base = sel[4'(n - 4'h1)] ? `PMICSQ_GAP_LONG_MS : `PMICSQ_GAP_SHORT_MS;
    gap_ms = (down && mult) ? 8'(base * `PMICSQ_DOWN_FACTOR) : base;
  endfunction : gap_ms

  // does a rail slot field name this slot
  function automatic logic rail_at(input logic [3:0] field, input logic [3:0] slot);
    rail_at = (field >= `PMICSQ_RAIL_SLOT_MIN) && (field <= `PMICSQ_SLOT_LAST)
              && (field == slot);
  endfunction : rail_at

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0] slot_delay_select_low;
  logic power_down_gap_multiplier;
  logic gap_select_9;
  logic [3:0] buck_rail1_slot;
  logic [3:0] buck_rail2_slot;
  logic unlocked;
  pmicsq_state_t state;
  pmicsq_state_t next_state;
  pmicsq_slot_t next_slot;
  logic gap_load;
  logic [7:0] gap_load_ms;
  logic gap_done;
  logic blank_busy;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup = psel && !penable;
  wire wr_now = psel && penable && pready && pwrite;
  wire [5:0] idx = paddr[7:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_lin = aligned && (idx == `PMICSQ_IDX_LIN_REG);
  wire hit_low = aligned && (idx == `PMICSQ_IDX_DLY_LOW);
  wire hit_high = aligned && (idx == `PMICSQ_IDX_DLY_HIGH);
  wire hit_rail = aligned && (idx == `PMICSQ_IDX_RAIL_SLOT);
  wire hit_stat = aligned && (idx == `PMICSQ_IDX_STATUS);
  wire hit_ctrl = aligned && (idx == `PMICSQ_IDX_CONTROL);
  wire hit_key = aligned && (idx == `PMICSQ_IDX_UNLOCK);
  wire hit_seq = hit_low || hit_high || hit_rail;
  wire mapped = hit_lin || hit_seq || hit_stat || hit_ctrl || hit_key;
  wire seq_wr_ok = wr_now && hit_seq && unlocked;
  wire lin_wr = wr_now && hit_lin;
  wire start_up = wr_now && hit_ctrl && pwdata[`PMICSQ_BIT_START_UP] && (state == PMICSQ_IDLE);
  wire start_down = wr_now && hit_ctrl && pwdata[`PMICSQ_BIT_START_DOWN] && !pwdata[`PMICSQ_BIT_START_UP]
                    && (state == PMICSQ_IDLE);
  wire [8:0] gap_sel = {gap_select_9, slot_delay_select_low};

  // read data selection
  wire [7:0] rd_byte =
    hit_lin ? {2'b00, linear_regulator_voltage} :
    hit_low ? slot_delay_select_low :
    hit_high ? {power_down_gap_multiplier, 6'b000000, gap_select_9} :
    hit_rail ? {buck_rail2_slot, buck_rail1_slot} :
    hit_stat ? {unlocked, blank_busy, state, slot_now} :
    8'h00;

  // apb answer: zero wait states, error on unmapped words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // ****************************************************************
  // protected sequence registers
  // ****************************************************************

  // unlock arms on the key, any other completed write disarms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked <= 1'b0;
    end else if (wr_now) begin
      unlocked <= hit_key && (pwdata[7:0] == `PMICSQ_UNLOCK_KEY);
    end
  end

  // sequence configuration storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_delay_select_low <= `PMICSQ_RST_DLY_LOW;
      power_down_gap_multiplier <= 1'(`PMICSQ_RST_DLY_HIGH >> `PMICSQ_BIT_MULT);
      gap_select_9 <= 1'(`PMICSQ_RST_DLY_HIGH & 8'h01);
      buck_rail1_slot <= 4'(`PMICSQ_RST_RAIL_SLOT & 8'h0F);
      buck_rail2_slot <= 4'(`PMICSQ_RST_RAIL_SLOT >> 4);
    end else if (seq_wr_ok) begin
      if (hit_low) begin
        slot_delay_select_low <= pwdata[7:0];
      end
      if (hit_high) begin
        power_down_gap_multiplier <= pwdata[`PMICSQ_BIT_MULT];
        gap_select_9 <= pwdata[`PMICSQ_BIT_GAP9];
      end
      if (hit_rail) begin
        buck_rail1_slot <= pwdata[3:0];
        buck_rail2_slot <= pwdata[7:4];
      end
    end
  end

  // ****************************************************************
  // linear regulator voltage and monitor blanking
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      linear_regulator_voltage <= `PMICSQ_RST_LIN_REG;
      lin_reg_target_mv <= `PMICSQ_RST_LIN_MV; // target of the reset code
      lin_reg_monitor_blank <= 1'b0;
    end else begin
      if (lin_wr) begin
        linear_regulator_voltage <= pwdata[5:0];
      end
      lin_reg_target_mv <= lin_code_mv(linear_regulator_voltage);
      lin_reg_monitor_blank <= lin_wr || blank_busy;
    end
  end

  // blanking window restarts on each write
  pmicsq_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_blank (
    .pclk(pclk),
    .presetn(presetn),
    .load(lin_wr),
    .load_ms(`PMICSQ_BLANK_MS),
    .busy(blank_busy),
    .done()
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // next state, next slot and gap timer load
  always_comb begin
    next_state = state;
    next_slot = slot_now;
    gap_load = 1'b0;
    gap_load_ms = 8'h0;
    unique case (state)
      PMICSQ_IDLE: begin
        if (start_up) begin
          next_state = PMICSQ_UP;
          next_slot = `PMICSQ_SLOT_FIRST;
          gap_load = 1'b1;
          gap_load_ms = gap_ms(gap_sel, `PMICSQ_SLOT_FIRST, 1'b0, power_down_gap_multiplier);
        end else if (start_down) begin
          next_state = PMICSQ_DOWN;
          next_slot = `PMICSQ_SLOT_LAST;
          gap_load = 1'b1;
          gap_load_ms = gap_ms(gap_sel, 4'(`PMICSQ_SLOT_LAST - 4'h1), 1'b1, power_down_gap_multiplier);
        end
      end
      PMICSQ_UP: begin
        if (gap_done) begin
          next_slot = slot_now + 4'h1;
          if (next_slot == `PMICSQ_SLOT_LAST) begin
            next_state = PMICSQ_IDLE;
          end else begin
            gap_load = 1'b1;
            gap_load_ms = gap_ms(gap_sel, next_slot, 1'b0, power_down_gap_multiplier);
          end
        end
      end
      PMICSQ_DOWN: begin
        if (gap_done) begin
          next_slot = slot_now - 4'h1;
          if (next_slot == `PMICSQ_SLOT_FIRST) begin
            next_state = PMICSQ_IDLE;
          end else begin
            gap_load = 1'b1;
            gap_load_ms = gap_ms(gap_sel, 4'(next_slot - 4'h1), 1'b1, power_down_gap_multiplier);
          end
        end
      end
      default: begin
        next_state = PMICSQ_IDLE;
      end
    endcase
  end

  wire strobe_now = (state == PMICSQ_IDLE) ? (start_up || start_down) : gap_done;
  wire going_down = (next_state == PMICSQ_DOWN) || (state == PMICSQ_DOWN);

  // state, slot and strobe registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PMICSQ_IDLE;
      slot_now <= 4'h0;
      slot_strobe <= 1'b0;
      seq_busy <= 1'b0;
    end else begin
      state <= next_state;
      slot_now <= next_slot;
      slot_strobe <= strobe_now;
      seq_busy <= (next_state != PMICSQ_IDLE);
    end
  end

  // rails switch at their slot, untouched when the field names none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_rail_one <= 1'b0;
      buck_rail_two <= 1'b0;
    end else if (strobe_now) begin
      if (rail_at(buck_rail1_slot, next_slot)) begin
        buck_rail_one <= !going_down;
      end
      if (rail_at(buck_rail2_slot, next_slot)) begin
        buck_rail_two <= !going_down;
      end
    end
  end

  // gap timer between consecutive slots
  pmicsq_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .load(gap_load),
    .load_ms(gap_load_ms),
    .busy(),
    .done(gap_done)
  );

endmodule : pmicsq_top

//--- pmicsq_asserts.sv
`timescale 1ns/1ps
module pmicsq_asserts #(
  parameter int CYC_PER_MS = 100000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // regulator, rails, sequencer
  input wire logic [5:0] linear_regulator_voltage,
  input wire logic [11:0] lin_reg_target_mv,
  input wire logic lin_reg_monitor_blank,
  input wire logic buck_rail_one,
  input wire logic buck_rail_two,
  input wire logic slot_strobe,
  input wire pmicsq_pkg::pmicsq_slot_t slot_now,
  input wire logic seq_busy
);
  import pmicsq_pkg::*;
  int gap_cnt;
  logic lin_wr;
  // completed write to the regulator code
  assign lin_wr = psel && penable && pready && pwrite && paddr == 8'h6C;
  // cycles since the last slot while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 0;
    end else if (slot_strobe || !seq_busy) begin
      gap_cnt <= 0;
    end else begin
      gap_cnt <= gap_cnt + 1;
    end
  end
  // millivolt target of a code
  function automatic logic [11:0] mv(input logic [5:0] c);
    return (c <= 6'h19) ? 12'h384 + 12'h019 * c : 12'h60E + 12'h032 * (c - 6'h1A);
  endfunction : mv
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_next: assert property (psel && !penable |=> pready && prdata[31:8] == 24'h000000)
    else $error("no ready in access cycle");
  chk_lin_reset: assert property ($rose(presetn) |-> linear_regulator_voltage == 6'h1F)
    else $error("regulator code not at reset value");
  chk_lin_target: assert property (lin_reg_target_mv == mv($past(linear_regulator_voltage)))
    else $error("target voltage wrong");
  chk_blank_hold: assert property (lin_wr |=> lin_reg_monitor_blank [*8])
    else $error("monitor blanking missing");
  chk_reserved_zero: assert property (pready && !pwrite && paddr == 8'h84 |-> prdata[6:1] == 6'h00)
    else $error("reserved bits not zero");
  chk_rail_on: assert property ($rose(buck_rail_one) || $rose(buck_rail_two)
    |-> slot_strobe && slot_now >= 4'h3 && slot_now <= 4'hA)
    else $error("rail enabled outside its slot");
  chk_rail_off: assert property ($fell(buck_rail_one) || $fell(buck_rail_two) |-> slot_strobe)
    else $error("rail disabled outside a slot");
  chk_gap_min: assert property (slot_strobe |=> !slot_strobe [*8])
    else $error("slots too close");
  chk_gap_max: assert property (gap_cnt <= 50 * CYC_PER_MS + 4)
    else $error("slot gap too long");
endmodule : pmicsq_asserts

//--- pmicsq_host.sv
`timescale 1ns/1ps
module pmicsq_host (
  // clock
  input wire logic pclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : pmicsq_host

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import pmicsq_pkg::*;
  localparam int CYC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [5:0] linear_regulator_voltage;
  logic [11:0] lin_reg_target_mv;
  logic lin_reg_monitor_blank, buck_rail_one, buck_rail_two, slot_strobe, seq_busy;
  pmicsq_slot_t slot_now;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  pmicsq_top #(.CYC_PER_MS(CYC)) pmicsq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .linear_regulator_voltage, .lin_reg_target_mv,
    .lin_reg_monitor_blank, .buck_rail_one, .buck_rail_two, .slot_strobe, .slot_now, .seq_busy);
  pmicsq_host pmicsq_host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    pmicsq_host_i.xfer(1'b1, a, d, rd_v, err);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    pmicsq_host_i.xfer(1'b0, a, 32'h0, rd_v, err);
  endtask : rd
  task automatic pwr(input logic [7:0] a, input logic [31:0] d);
    wr(8'hC8, 32'hA5); // key first
    wr(a, d);
  endtask : pwr
  // reset values and an unmapped place
  task automatic t_reset();
    logic [7:0] adr [4] = '{8'h6C, 8'h80, 8'h84, 8'h88};
    logic [31:0] rst [4] = '{32'h1F, 32'h0, 32'h0, 32'h55};
    check(32'(lin_reg_target_mv), 32'h708);
    foreach (adr[i]) begin
      rd(adr[i]);
      check(rd_v, rst[i]);
    end
    rd(8'h10);
    check({rd_v[30:0], err}, 32'h1);
  endtask : t_reset
  // every regulator code, then blanking length
  task automatic t_lin();
    int n;
    for (int c = 0; c < 64; c++) begin
      wr(8'h6C, 32'(c));
      rd(8'h6C);
      check(rd_v, 32'(c));
      check(32'(lin_reg_target_mv), c < 26 ? 32'h384 + 32'h19 * c : 32'h60E + 32'h32 * (c - 26));
      check(32'(lin_reg_monitor_blank), 32'h1);
    end
    n = 0;
    while (lin_reg_monitor_blank === 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n >= 90 && n <= 102), 32'h1);
  endtask : t_lin
  // locked writes dropped, reserved bits
  task automatic t_lock();
    wr(8'h80, 32'hFF);
    pwr(8'h80, 32'hA6);
    wr(8'h80, 32'h00);
    rd(8'h80);
    check(rd_v, 32'hA6);
    pwr(8'h84, 32'hFF);
    rd(8'h84);
    check(rd_v, 32'h81);
  endtask : t_lock
  // one sequence, gaps and rails judged at each slot
  task automatic run(input logic up, input logic [8:0] g, input logic m, input logic [7:0] f, input logic [1:0] r);
    int n, want, p;
    logic [3:0] s;
    n = 0;
    while (seq_busy !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    wr(8'hC4, up ? 32'h1 : 32'h2);
    for (int k = 0; k < 10; k++) begin
      s = up ? 4'(k + 1) : 4'(10 - k);
      p = up ? k : 11 - k;
      n = 0;
      // the first strobe stands in the cycle right after the start write
      if (k > 0) begin
        want = (g[up ? p - 1 : p - 2] ? 5 : 2) * CYC * ((!up && m) ? 10 : 1);
        do begin
          @(posedge pclk);
          n++;
        end while (slot_strobe !== 1'b1 && n < 1100);
        check(32'(n >= want && n <= want + 2), 32'h1);
      end
      check(32'(slot_strobe), 32'h1);
      if (f[3:0] >= 4'h3 && f[3:0] <= 4'hA && s == f[3:0]) r[0] = up;
      if (f[7:4] >= 4'h3 && f[7:4] <= 4'hA && s == f[7:4]) r[1] = up;
      check(32'({seq_busy, buck_rail_two, buck_rail_one, slot_now}), 32'({k < 9, r, s}));
    end
  endtask : run
  task automatic t_seq();
    pwr(8'h80, 32'h55);
    pwr(8'h88, 32'h3A);
    run(1'b1, 9'h155, 1'b1, 8'h3A, 2'b00);
    pwr(8'h88, 32'hB2);
    run(1'b0, 9'h155, 1'b1, 8'hB2, 2'b11);
    pwr(8'h84, 32'h01);
    pwr(8'h88, 32'h3A);
    run(1'b0, 9'h155, 1'b0, 8'h3A, 2'b11);
    pwr(8'h88, 32'hB2);
    run(1'b1, 9'h155, 1'b0, 8'hB2, 2'b00);
  endtask : t_seq
  // main sequence
  initial begin
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_lin();
    t_lock();
    t_seq();
    stop_test();
  end
endmodule : tb
bind pmicsq_top pmicsq_asserts #(.CYC_PER_MS(CYC_PER_MS)) pmicsq_asserts_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .linear_regulator_voltage, .lin_reg_target_mv, .lin_reg_monitor_blank,
  .buck_rail_one, .buck_rail_two, .slot_strobe, .slot_now, .seq_busy);
